// File: design/self_prog_pkg.sv
// Constants, register offsets and timing for the flash self-programming block
// Assumes a 100 MHz CPU clock and a plain one-cycle strobe register port
package self_prog_pkg;

	// ---------------------------------------------------------------
	// Register offsets
	// ---------------------------------------------------------------
	localparam logic [3:0] OFS_MODE_CTRL = 4'h0;
	localparam logic [3:0] OFS_UNLOCK = 4'h1;
	localparam logic [3:0] OFS_STATUS = 4'h2;
	localparam logic [3:0] OFS_COMMAND = 4'h3;
	localparam logic [3:0] OFS_ADDR_HIGH = 4'h4;
	localparam logic [3:0] OFS_ADDR_LOW = 4'h5;
	localparam logic [3:0] OFS_CMP_HIGH = 4'h6;
	localparam logic [3:0] OFS_CMP_LOW = 4'h7;
	localparam logic [3:0] OFS_WRITE_BUF = 4'h8;

	// ---------------------------------------------------------------
	// Fields and values
	// ---------------------------------------------------------------
	localparam logic [7:0] UNLOCK_KEY = 8'ha5;
	localparam int MODE_BIT = 0;
	localparam int ERR_BIT = 0;
	localparam int BUSY_BIT = 1;
	localparam int PROT_WR_BIT = 0;
	localparam int PROT_ER_BIT = 1;
	localparam logic [7:0] ERASED_BYTE = 8'hff;
	localparam logic [15:0] PROTECT_ADDR = 16'h0081;
	localparam logic [7:0] PROTECT_RESET = 8'hff;
	localparam logic [3:0] HIGH_ADDR_MASK = 4'hf;

	typedef enum logic [2:0] {
		CMD_NONE = 3'b000,
		CMD_VERIFY1 = 3'b001,
		CMD_VERIFY2 = 3'b010,
		CMD_ERASE = 3'b011,
		CMD_BLANK = 3'b100,
		CMD_WRITE = 3'b101
	} op_cmd_t;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int CLK_MHZ = 100;
	localparam int T_VERIFY1_NS = 6800000;
	localparam int T_VERIFY2_NS = 27000;
	localparam int T_ERASE_NS = 8500000;
	localparam int T_BLANK_NS = 480000;
	localparam int T_WRITE_NS = 150000;
	localparam int T_ENTRY_NS = 10000;
	localparam int CLK_PERIOD_NS = 1000 / CLK_MHZ;
	// All times round down; the entry wait then gets two cycles more
	localparam int CYC_VERIFY1 = T_VERIFY1_NS / CLK_PERIOD_NS;
	localparam int CYC_VERIFY2 = T_VERIFY2_NS / CLK_PERIOD_NS;
	localparam int CYC_ERASE = T_ERASE_NS / CLK_PERIOD_NS;
	localparam int CYC_BLANK = T_BLANK_NS / CLK_PERIOD_NS;
	localparam int CYC_WRITE = T_WRITE_NS / CLK_PERIOD_NS;
	localparam int CYC_ENTRY = T_ENTRY_NS / CLK_PERIOD_NS + 2;
	localparam int CNT_W = 24;

endpackage

// File: design/flash_array.sv
// Flash array model with byte write, block erase and registered byte read
// Assumes one operation at a time, started by the sequencer
`timescale 1ns/1ps
module flash_array
	import self_prog_pkg::*;
#(
	parameter int ADDR_W = 12,
	parameter int BLK_W = 8
) (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic [ADDR_W-1:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic write_in,
	input wire logic erase_in,
	output logic [7:0] rdata_out,
	output logic [7:0] prot_out
);

	localparam int DEPTH = 1 << ADDR_W;
	localparam int BLK_SIZE = 1 << BLK_W;

	// Starts from a factory-erased array so the protect byte is known
	logic [7:0] mem [DEPTH] = '{default: ERASED_BYTE};
	logic [ADDR_W-1:0] blk_base;

	assign blk_base = {addr_in[ADDR_W-1:BLK_W], {BLK_W{1'b0}}};

	// ---------------------------------------------------------------
	// Storage
	// ---------------------------------------------------------------
	// Erase fills a block in one edge; the timer upstream stands for the
	// real array time, so the model itself needs no slow loop.
	always_ff @(posedge clk_in) begin
		if (erase_in) begin
			for (int i = 0; i < BLK_SIZE; i++) begin
				mem[blk_base + ADDR_W'(i)] <= ERASED_BYTE;
			end
		end else if (write_in) begin
			mem[addr_in] <= mem[addr_in] & wdata_in;
		end
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rdata_out <= 8'h00;
			prot_out <= PROTECT_RESET;
		end else begin
			rdata_out <= mem[addr_in];
			prot_out <= mem[PROTECT_ADDR[ADDR_W-1:0]];
		end
	end

endmodule

// File: design/flash_self_program_sequencer.sv
// Self-programming sequencer: unlock, mode control, command timing
// Assumes the CPU raises halt_in for one cycle when it executes a halt
//
// The register offsets and the strobed register port were decided locally.
`timescale 1ns/1ps
module flash_self_program_sequencer
	import self_prog_pkg::*;
#(
	parameter int ADDR_W = 12,
	parameter int BLK_W = 8,
	parameter int VERIFY1_CYC = CYC_VERIFY1,
	parameter int VERIFY2_CYC = CYC_VERIFY2,
	parameter int ERASE_CYC = CYC_ERASE,
	parameter int BLANK_CYC = CYC_BLANK,
	parameter int WRITE_CYC = CYC_WRITE
) (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic [3:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [7:0] rdata_out,
	input wire logic halt_in,
	input wire logic irq_in,
	output logic cpu_stall_out,
	output logic irq_out,
	output logic pins_hold_out,
	output logic self_prog_mode_out
);

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ENTRY = 2'b01,
		ST_RUN = 2'b10
	} seq_state_t;

	seq_state_t state_r;
	logic unlock_r;
	logic mode_r;
	logic err_r;
	logic irq_pend_r;
	logic [7:0] cmd_r;
	logic [7:0] addr_high_r;
	logic [7:0] addr_low_r;
	logic [7:0] cmp_high_r;
	logic [7:0] cmp_low_r;
	logic [7:0] wbuf_r;
	logic [CNT_W-1:0] cnt_r;
	logic [ADDR_W-1:0] scan_addr_r;
	logic scan_first_r;
	logic [ADDR_W-1:0] flash_addr;
	logic [7:0] flash_rdata;
	logic [7:0] prot_byte;
	logic fl_write;
	logic fl_erase;
	logic blocked;
	logic start;
	logic done;
	logic scanning;
	logic scan_bad;
	logic [ADDR_W-1:0] ptr_addr;
	logic [ADDR_W-1:0] cmp_addr;

	// Any width of pointer wider than the array folds onto its low bits
	function automatic logic [ADDR_W-1:0] join_addr(input logic [7:0] hi,
			input logic [7:0] lo);
		logic [15:0] full;
		full = {hi, lo};
		return full[ADDR_W-1:0];
	endfunction

	function automatic logic [CNT_W-1:0] op_cycles(input logic [7:0] cmd);
		case (cmd[2:0])
			CMD_VERIFY1: return CNT_W'(VERIFY1_CYC);
			CMD_VERIFY2: return CNT_W'(VERIFY2_CYC);
			CMD_ERASE: return CNT_W'(ERASE_CYC);
			CMD_BLANK: return CNT_W'(BLANK_CYC);
			CMD_WRITE: return CNT_W'(WRITE_CYC);
			default: return CNT_W'(1);
		endcase
	endfunction

	assign ptr_addr = join_addr(addr_high_r, addr_low_r);
	assign cmp_addr = join_addr(cmp_high_r, cmp_low_r);

	// ---------------------------------------------------------------
	// Register port
	// ---------------------------------------------------------------
	// The unlock key arms exactly the next write; any other write disarms
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			unlock_r <= 1'b0;
		end else if (wr_in) begin
			unlock_r <= (addr_in == OFS_UNLOCK) && (wdata_in == UNLOCK_KEY);
		end
	end

	// Mode is undefined after reset in silicon; here it clears to normal
	// mode so that a reset never leaves the CPU locked out of interrupts.
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			mode_r <= 1'b0;
		end else if (wr_in && addr_in == OFS_MODE_CTRL && unlock_r &&
				state_r == ST_IDLE) begin
			mode_r <= wdata_in[MODE_BIT];
		end
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			cmd_r <= 8'h00;
			addr_high_r <= 8'h00;
			addr_low_r <= 8'h00;
			cmp_high_r <= 8'h00;
			cmp_low_r <= 8'h00;
			wbuf_r <= 8'h00;
		end else if (wr_in && state_r == ST_IDLE) begin
			case (addr_in)
				OFS_COMMAND: cmd_r <= wdata_in;
				OFS_ADDR_HIGH: addr_high_r <= wdata_in;
				OFS_ADDR_LOW: addr_low_r <= wdata_in;
				OFS_CMP_HIGH: cmp_high_r <= wdata_in;
				OFS_CMP_LOW: cmp_low_r <= wdata_in;
				OFS_WRITE_BUF: wbuf_r <= wdata_in;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rdata_out <= 8'h00;
		end else if (rd_in) begin
			case (addr_in)
				OFS_MODE_CTRL: rdata_out <= {prot_byte[7:1], mode_r};
				OFS_STATUS: rdata_out <= {6'h00, state_r != ST_IDLE, err_r};
				OFS_COMMAND: rdata_out <= cmd_r;
				OFS_ADDR_HIGH: rdata_out <= addr_high_r;
				OFS_ADDR_LOW: rdata_out <= addr_low_r;
				OFS_CMP_HIGH: rdata_out <= cmp_high_r;
				OFS_CMP_LOW: rdata_out <= cmp_low_r;
				OFS_WRITE_BUF: rdata_out <= wbuf_r;
				default: rdata_out <= 8'h00;
			endcase
		end else begin
			rdata_out <= 8'h00;
		end
	end

	// ---------------------------------------------------------------
	// Sequencer
	// ---------------------------------------------------------------
	// External security is not consulted; only the protect byte blocks
	assign blocked = (cmd_r[2:0] == CMD_WRITE && !prot_byte[PROT_WR_BIT]) ||
		(cmd_r[2:0] == CMD_ERASE && !prot_byte[PROT_ER_BIT]);
	assign start = halt_in && mode_r && state_r == ST_IDLE;
	assign done = state_r != ST_IDLE && cnt_r == '0;

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state_r <= ST_IDLE;
			cnt_r <= '0;
		end else begin
			case (state_r)
				ST_IDLE: begin
					if (start && cmd_r[2:0] == CMD_NONE) begin
						state_r <= ST_ENTRY;
						cnt_r <= CNT_W'(CYC_ENTRY - 1);
					end else if (start) begin
						state_r <= ST_RUN;
						cnt_r <= op_cycles(cmd_r) - CNT_W'(1);
					end
				end
				ST_ENTRY, ST_RUN: begin
					if (done) begin
						state_r <= ST_IDLE;
					end else begin
						cnt_r <= cnt_r - CNT_W'(1);
					end
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Block scan for verify and blank check
	// ---------------------------------------------------------------
	// Verify 2 walks from the pointer, the others from the block start, each up to the compare pointer or the block end
	assign scanning = state_r == ST_RUN && !scan_first_r &&
		(cmd_r[2:0] == CMD_BLANK || cmd_r[2:0] == CMD_VERIFY1 ||
		cmd_r[2:0] == CMD_VERIFY2);
	assign scan_bad = scanning && cmd_r[2:0] == CMD_BLANK &&
		flash_rdata != ERASED_BYTE;

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			scan_addr_r <= '0;
			scan_first_r <= 1'b0;
		end else if (start) begin
			scan_addr_r <= (cmd_r[2:0] == CMD_VERIFY2) ? ptr_addr :
				{ptr_addr[ADDR_W-1:BLK_W], {BLK_W{1'b0}}};
			scan_first_r <= 1'b1;
		end else if (state_r == ST_RUN) begin
			scan_first_r <= 1'b0;
			if (scan_addr_r != cmp_addr &&
					scan_addr_r[BLK_W-1:0] != {BLK_W{1'b1}}) begin
				scan_addr_r <= scan_addr_r + ADDR_W'(1);
			end
		end
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			err_r <= 1'b0;
		end else if (start) begin
			err_r <= blocked;
		end else if (scan_bad) begin
			err_r <= 1'b1;
		end
	end

	assign fl_write = start && cmd_r[2:0] == CMD_WRITE && !blocked;
	assign fl_erase = start && cmd_r[2:0] == CMD_ERASE && !blocked;
	assign flash_addr = (state_r == ST_RUN) ? scan_addr_r : ptr_addr;

	flash_array #(
		.ADDR_W(ADDR_W),
		.BLK_W(BLK_W)
	) u_array (
		.clk_in(clk_in),
		.resetn_in(resetn_in),
		.addr_in(flash_addr),
		.wdata_in(wbuf_r),
		.write_in(fl_write),
		.erase_in(fl_erase),
		.rdata_out(flash_rdata),
		.prot_out(prot_byte)
	);

	// ---------------------------------------------------------------
	// CPU side: stall, interrupts and pins
	// ---------------------------------------------------------------
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			irq_pend_r <= 1'b0;
		end else if (mode_r && irq_in) begin
			irq_pend_r <= 1'b1;
		end else if (!mode_r) begin
			irq_pend_r <= 1'b0;
		end
	end

	assign irq_out = !mode_r && (irq_in || irq_pend_r);
	assign cpu_stall_out = state_r != ST_IDLE;
	assign pins_hold_out = mode_r;
	assign self_prog_mode_out = mode_r;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	// The entry wait is longer than a delay range may span, so its
	// length is counted here and the properties test the count.
	// The count restarts at every accepted halt, so a command that
	// follows an entry never inherits the entry's figure.
	logic [CNT_W-1:0] entry_len_r;

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			entry_len_r <= '0;
		end else if (start) begin
			entry_len_r <= '0;
		end else if (state_r == ST_ENTRY) begin
			entry_len_r <= entry_len_r + CNT_W'(1);
		end
	end

	chk_mode_needs_unlock: assert property (@(posedge clk_in)
		disable iff (!resetn_in)
		$changed(mode_r) |-> $past(unlock_r))
		else $error("mode changed without unlock");

	chk_halt_starts_op: assert property (@(posedge clk_in)
		disable iff (!resetn_in)
		start |=> cpu_stall_out)
		else $error("halt in mode did not stall cpu");

	chk_op_release: assert property (@(posedge clk_in)
		disable iff (!resetn_in)
		state_r == ST_RUN && cnt_r == '0 |=> !cpu_stall_out)
		else $error("halt not released after command");

	chk_halt_ignored: assert property (@(posedge clk_in)
		disable iff (!resetn_in)
		halt_in && !mode_r |=> !cpu_stall_out)
		else $error("halt outside mode stalled cpu");

	chk_no_irq_in_mode: assert property (@(posedge clk_in)
		disable iff (!resetn_in)
		mode_r |-> !irq_out)
		else $error("interrupt passed during mode");

	chk_irq_held: assert property (@(posedge clk_in)
		disable iff (!resetn_in)
		mode_r && irq_in ##1 $fell(mode_r) |-> irq_out)
		else $error("held interrupt lost");

	chk_entry_hold: assert property (@(posedge clk_in)
		disable iff (!resetn_in)
		start && cmd_r[2:0] == CMD_NONE |=> cpu_stall_out [*8])
		else $error("entry halt released too early");

	chk_entry_bound: assert property (@(posedge clk_in)
		disable iff (!resetn_in)
		state_r == ST_ENTRY |-> entry_len_r < CNT_W'(CYC_ENTRY))
		else $error("entry halt held too long");

	chk_entry_release: assert property (@(posedge clk_in)
		disable iff (!resetn_in)
		$fell(cpu_stall_out) && entry_len_r != '0 |->
		entry_len_r == CNT_W'(CYC_ENTRY))
		else $error("entry halt release time wrong");

	chk_stall_no_mode_change: assert property (@(posedge clk_in)
		disable iff (!resetn_in)
		cpu_stall_out |=> $stable(mode_r))
		else $error("mode changed while busy");

	chk_blocked_sets_err: assert property (@(posedge clk_in)
		disable iff (!resetn_in)
		start && blocked |-> !fl_write && !fl_erase ##1 err_r)
		else $error("protect byte not honoured");

	chk_blank_sets_err: assert property (@(posedge clk_in)
		disable iff (!resetn_in)
		scan_bad |=> err_r)
		else $error("blank check miss not flagged");

	chk_pins_follow_mode: assert property (@(posedge clk_in)
		disable iff (!resetn_in)
		pins_hold_out == mode_r)
		else $error("pins not held in mode");

	chk_mode_read: assert property (@(posedge clk_in)
		disable iff (!resetn_in)
		rd_in && addr_in == OFS_MODE_CTRL |=> rdata_out[0] == mode_r)
		else $error("mode control read wrong");

endmodule

// File: verif/flash_self_program_sequencer_tb.sv
// Self-checking bench for the flash self-programming sequencer
// Assumes the sequencer holds its own flash array and the package entry timing
`timescale 1ns/1ps
module flash_self_program_sequencer_tb
	import self_prog_pkg::*;
;
	// ---------------------------------------------------------------
	// Shortened operation times, all above one block scan
	// ---------------------------------------------------------------
	localparam int V1_CYC = 300;
	localparam int V2_CYC = 304;
	localparam int ER_CYC = 308;
	localparam int BL_CYC = 312;
	localparam int WR_CYC = 316;
	// Settling wait after the entry halt, 8 us at 10 ns
	localparam int SETTLE_CYC = 800;

	logic clk_in = 1'b0;
	logic resetn_in = 1'b0;
	logic [3:0] addr_in = 4'h0;
	logic [7:0] wdata_in = 8'h00;
	logic wr_in = 1'b0;
	logic rd_in = 1'b0;
	logic halt_in = 1'b0;
	logic irq_in = 1'b0;
	logic [7:0] rdata_out;
	logic cpu_stall_out;
	logic irq_out;
	logic pins_hold_out;
	logic self_prog_mode_out;
	int n_mismatch = 0;
	int tests_run = 0;

	always #5 clk_in = ~clk_in;

	flash_self_program_sequencer #(
		.VERIFY1_CYC(V1_CYC),
		.VERIFY2_CYC(V2_CYC),
		.ERASE_CYC(ER_CYC),
		.BLANK_CYC(BL_CYC),
		.WRITE_CYC(WR_CYC)
	) dut (
		.clk_in(clk_in),
		.resetn_in(resetn_in),
		.addr_in(addr_in),
		.wdata_in(wdata_in),
		.wr_in(wr_in),
		.rd_in(rd_in),
		.rdata_out(rdata_out),
		.halt_in(halt_in),
		.irq_in(irq_in),
		.cpu_stall_out(cpu_stall_out),
		.irq_out(irq_out),
		.pins_hold_out(pins_hold_out),
		.self_prog_mode_out(self_prog_mode_out)
	);

	// ---------------------------------------------------------------
	// Reporting
	// ---------------------------------------------------------------
	task automatic check(input string what, input logic [15:0] seen,
			input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// ---------------------------------------------------------------
	// Register port and halt tasks
	// ---------------------------------------------------------------
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_in);
		wr_in <= 1'b1;
		addr_in <= a;
		wdata_in <= d;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask

	// Read data stands only in the cycle after the strobe
	task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
		@(posedge clk_in);
		rd_in <= 1'b1;
		addr_in <= a;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1;
		v = rdata_out;
	endtask

	// Key and mode writes back to back, as the guard needs
	task automatic enter(input logic [7:0] key, input logic [7:0] v);
		@(posedge clk_in);
		wr_in <= 1'b1;
		addr_in <= OFS_UNLOCK;
		wdata_in <= key;
		@(posedge clk_in);
		addr_in <= OFS_MODE_CTRL;
		wdata_in <= v;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask

	// Counts cycles of stall after one halt pulse, bounded
	task automatic halt_len(output int n);
		@(posedge clk_in);
		halt_in <= 1'b1;
		@(posedge clk_in);
		halt_in <= 1'b0;
		n = 0;
		// The stall is already up just after the edge that took the halt
		for (int i = 0; i < 2000; i++) begin
			#1;
			if (cpu_stall_out !== 1'b1) return;
			n++;
			@(posedge clk_in);
		end
		check("stall bound", 16'h0001, 16'h0000);
		close_out();
	endtask

	task automatic run_cmd(input op_cmd_t c, input logic [15:0] a,
			input int exp);
		int n;
		wr_reg(OFS_ADDR_HIGH, a[15:8] & 8'h0f);
		wr_reg(OFS_ADDR_LOW, a[7:0]);
		wr_reg(OFS_CMP_HIGH, a[15:8] & 8'h0f);
		wr_reg(OFS_CMP_LOW, a[7:0]);
		wr_reg(OFS_COMMAND, {5'h00, c});
		halt_len(n);
		check("op cycles", n[15:0], exp[15:0]);
	endtask

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		logic [7:0] v;
		logic [7:0] d;
		logic [15:0] a;
		int n;
		void'($urandom(97));
		repeat (6) @(posedge clk_in);
		resetn_in <= 1'b1;
		@(posedge clk_in);
		#1;
		check("mode after reset", self_prog_mode_out, 16'h0000);
		// Mode write without the key, then with a wrong key
		wr_reg(OFS_MODE_CTRL, 8'h01);
		@(posedge clk_in);
		#1;
		check("mode unkeyed", self_prog_mode_out, 16'h0000);
		d = 8'($urandom);
		if (d == UNLOCK_KEY) d = 8'h5a;
		enter(d, 8'h01);
		@(posedge clk_in);
		#1;
		check("mode bad key", self_prog_mode_out, 16'h0000);
		wr_reg(OFS_COMMAND, 8'h00);
		irq_in <= 1'b1;
		enter(UNLOCK_KEY, 8'h01);
		@(posedge clk_in);
		#1;
		check("mode keyed", self_prog_mode_out, 16'h0001);
		check("pins hold", pins_hold_out, 16'h0001);
		check("irq in mode", irq_out, 16'h0000);
		rd_reg(OFS_MODE_CTRL, v);
		check("mode read", v[0], 16'h0001);
		halt_len(n);
		check("entry cycles", n[15:0], CYC_ENTRY[15:0]);
		repeat (SETTLE_CYC) @(posedge clk_in);
		// Random requests must stay unserviced while in the mode
		repeat (8) begin
			@(posedge clk_in);
			irq_in <= 1'($urandom);
			#1;
			check("irq masked", irq_out, 16'h0000);
		end
		irq_in <= 1'b1;
		// Erase the block holding the protect byte so it is defined
		run_cmd(CMD_ERASE, 16'h0000, ER_CYC);
		run_cmd(CMD_ERASE, 16'h0100, ER_CYC);
		run_cmd(CMD_BLANK, 16'h0100, BL_CYC);
		rd_reg(OFS_STATUS, v);
		check("blank after erase", v, 16'h0000);
		a = 16'h0100 | 16'($urandom & 8'hff);
		d = 8'($urandom) & 8'hfe;
		wr_reg(OFS_WRITE_BUF, d);
		run_cmd(CMD_WRITE, a, WR_CYC);
		run_cmd(CMD_BLANK, a, BL_CYC);
		rd_reg(OFS_STATUS, v);
		check("blank after write", v, 16'h0001);
		run_cmd(CMD_VERIFY1, a, V1_CYC);
		rd_reg(OFS_STATUS, v);
		check("status verify", v, 16'h0000);
		run_cmd(CMD_VERIFY2, a, V2_CYC);
		// Clear the write-protect bit of the protect byte, keep erase open
		wr_reg(OFS_WRITE_BUF, 8'h7e);
		run_cmd(CMD_WRITE, PROTECT_ADDR, WR_CYC);
		rd_reg(OFS_MODE_CTRL, v);
		check("protect readback", v, 16'h007f);
		run_cmd(CMD_WRITE, a, WR_CYC);
		rd_reg(OFS_STATUS, v);
		check("write refused", v[0], 16'h0001);
		// Erase is still allowed and reopens writes
		repeat (2) run_cmd(CMD_ERASE, 16'h0000, ER_CYC);
		rd_reg(OFS_MODE_CTRL, v);
		check("protect erased", v, 16'h00ff);
		rd_reg(4'hf, v);
		check("unmapped read", v, 16'h0000);
		// Leave the mode with the request gone; only the held copy shows
		irq_in <= 1'b0;
		wr_reg(OFS_COMMAND, 8'h00);
		enter(UNLOCK_KEY, 8'h00);
		#1;
		check("irq held", irq_out, 16'h0001);
		irq_in <= 1'b1;
		@(posedge clk_in);
		#1;
		check("mode left", self_prog_mode_out, 16'h0000);
		check("pins free", pins_hold_out, 16'h0000);
		check("irq after mode", irq_out, 16'h0001);
		halt_len(n);
		check("halt outside mode", n[15:0], 16'h0000);
		close_out();
	end
endmodule
